// >>> fgcw_host.sv
`timescale 1ns/1ps
module fgcw_host
  import fgcw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output fgcw_pkg::fgcw_req_s req,
  output logic            sda_in
);
  logic sda_lo = 1'b0;
  // line has a pull-up: released means high
  assign sda_in = ~sda_lo;
  initial req = '0;
  // ==========================================
  // one strobe per access, each a valid transaction
  task xfer(input logic w, input logic [7:0] dat, output logic [7:0] q);
    @(posedge clk);
    #1 req = '{wr: w, rd: !w, addr: 8'h00, wdata: dat, txn_ok: 1'b1};
    @(posedge clk);
    #1 q = rdata;
    req = '0;
  endtask
endmodule // fgcw_host

// >>> fgcw_map.svh
`ifndef FGCW_MAP_SVH
`define FGCW_MAP_SVH
`define FGCW_OFS_CONFIG      8'h00
`define FGCW_BIT_STANDBY     7
`define FGCW_BIT_SOFT_RESET  6
`define FGCW_BIT_TMO_OFF     5
`define FGCW_BIT_FAIL_FULL   4
`define FGCW_BIT_XTAL_SEL    3
`define FGCW_BIT_WD_HI       2
`define FGCW_BIT_WD_LO       1
`define FGCW_BIT_WD_STAT     0
`define FGCW_RESET_UPPER     5'h00
`define FGCW_CLK_NS          8
`define FGCW_BUS_TMO_MS      35
`define FGCW_BUS_TMO_CYC     ((`FGCW_BUS_TMO_MS * 1000000) / `FGCW_CLK_NS)
`define FGCW_WD_P1_S         2
`define FGCW_WD_P2_S         6
`define FGCW_WD_P3_S         10
`define FGCW_TICK_CYC        32'd125_000_000
`define FGCW_XTAL_EDGES      16'd1024
`define FGCW_XTAL_DEAD_CYC   32'd1_000_000
`endif

// >>> fgcw_pkg.sv
package fgcw_pkg;
  typedef struct packed {
    logic       standby;
    logic       tmo_off;
    logic       fail_full_off;
    logic       xtal_sel;
    logic [1:0] wd_period;
    logic       wd_status;
  } fgcw_cfg_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       txn_ok;
  } fgcw_req_s;
  typedef enum logic [2:0] {
    FGCW_OSC_INT  = 3'b001,
    FGCW_OSC_WAIT = 3'b010,
    FGCW_OSC_XTAL = 3'b100
  } fgcw_osc_e;
endpackage

// >>> fgcw_properties.sv
`timescale 1ns/1ps
module fgcw_properties
  import fgcw_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire fgcw_req_s  req,
  input wire logic       sda_in,
  input wire logic       xtal_clk,
  input wire logic       watchdog_start_pin,
  input wire logic       fan_fail_any,
  input wire logic [7:0] rdata,
  input wire fgcw_cfg_s  cfg,
  input wire logic       standby,
  input wire logic       bus_reset,
  input wire logic       regs_reset,
  input wire logic       all_fans_full,
  input wire logic       hold_drive,
  input wire logic       use_xtal
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire rd0 = req.rd && req.addr == 8'h00;
  wire wr0 = req.wr && req.addr == 8'h00;
  // ==========================================
  // register, watchdog, fan-fail, bus timeout and oscillator relations
  a_bit6_zero: assert property (rd0 |=> !rdata[6])
    else $error("bit6 read one");
  a_run_bit: assert property (rd0 |=> rdata[7] == standby)
    else $error("standby mismatch");
  a_soft_rst: assert property (wr0 && req.wdata[6] |-> ##[1:2] regs_reset)
    else $error("no regs reset");
  a_rst_pulse: assert property (regs_reset |=> !regs_reset)
    else $error("regs reset held");
  a_fail_full: assert property (
    fan_fail_any && !cfg.fail_full_off |-> ##[1:2] all_fans_full)
    else $error("fail not full");
  a_xtal_sel: assert property ($rose(use_xtal) |-> cfg.xtal_sel)
    else $error("xtal without select");
  // expiry in the read cycle may set the status again
  a_stat_clr: assert property (rd0 |=> !cfg.wd_status || $rose(hold_drive))
    else $error("status not cleared");
  a_wd_restore: assert property (req.txn_ok |=> !hold_drive)
    else $error("drive not restored");
  a_wd_fire: assert property ($rose(hold_drive) |->
    all_fans_full && cfg.wd_status && $past(cfg.wd_period) != 2'b00)
    else $error("bad watchdog fire");
  a_bus_tmo: assert property (bus_reset |->
    !$past(cfg.tmo_off) && !$past(sda_in, 3))
    else $error("bad bus reset");
  c_wd: cover property ($rose(hold_drive));
  c_tmo: cover property (bus_reset);
  c_xtal: cover property ($rose(use_xtal));
endmodule // fgcw_properties

bind fgcw_top fgcw_properties u_props (.clk, .rstn, .req, .sda_in,
  .xtal_clk, .watchdog_start_pin, .fan_fail_any, .rdata, .cfg, .standby,
  .bus_reset, .regs_reset, .all_fans_full, .hold_drive, .use_xtal);

// >>> fgcw_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pins from outside the clock domain
module fgcw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;
  always_comb begin
    next_meta = rstn ? din : '0;
    next_dout = rstn ? meta : '0;
  end
  always_ff @(posedge clk) begin
    meta <= next_meta;
    dout <= next_dout;
  end
endmodule // fgcw_sync

// >>> fgcw_top.sv
`timescale 1ns/1ps
`include "fgcw_map.svh"
module fgcw_top #(
  parameter int unsigned BUS_TMO_CYC = `FGCW_BUS_TMO_CYC,
  parameter int unsigned TICK_CYC    = `FGCW_TICK_CYC,
  parameter int unsigned XTAL_EDGES  = `FGCW_XTAL_EDGES,
  parameter int unsigned XTAL_DEAD   = `FGCW_XTAL_DEAD_CYC
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire fgcw_pkg::fgcw_req_s req,
  input  wire logic             sda_in,
  input  wire logic             xtal_clk,
  input  wire logic             watchdog_start_pin,
  input  wire logic             fan_fail_any,
  output logic [7:0]            rdata,
  output fgcw_pkg::fgcw_cfg_s   cfg,
  output logic                  standby,
  output logic                  bus_reset,
  output logic                  regs_reset,
  output logic                  all_fans_full,
  output logic                  hold_drive,
  output logic                  use_xtal
);
  import fgcw_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [2:0] pins_s;
  fgcw_sync #(.W(3)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({sda_in, xtal_clk, watchdog_start_pin}),
    .dout (pins_s)
  );
  logic sda_s, xclk_s, wd_pin_s;
  assign sda_s    = pins_s[2];
  assign xclk_s   = pins_s[1];
  assign wd_pin_s = pins_s[0];

  function automatic logic [31:0] wd_cycles(input logic [1:0] f);
    case (f)
      2'b01:   wd_cycles = 32'(`FGCW_WD_P1_S);
      2'b10:   wd_cycles = 32'(`FGCW_WD_P2_S);
      2'b11:   wd_cycles = 32'(`FGCW_WD_P3_S);
      default: wd_cycles = 32'h0000_0000;
    endcase
  endfunction

  // ==========================================================
  // configuration register
  logic [1:0] strap_cnt, next_strap_cnt;
  fgcw_cfg_s  next_cfg;
  logic [7:0] next_rdata;
  logic       next_regs_reset;
  logic       wd_expire;
  logic       cfg_hit;
  assign cfg_hit = req.addr == `FGCW_OFS_CONFIG;

  always_comb begin
    next_cfg        = cfg;
    next_rdata      = rdata;
    next_strap_cnt  = (strap_cnt == 2'h3) ? 2'h3 : strap_cnt + 2'h1;
    next_regs_reset = 1'b0;
    // power-up value of the period is reloaded until the pin has crossed
    // the synchroniser; a write in the first two of those cycles would be overwritten
    if (strap_cnt != 2'h3)
      next_cfg.wd_period = wd_pin_s ? 2'b11 : 2'b00;
    if (req.rd && cfg_hit) begin
      // soft-reset bit reads as zero
      next_rdata = {cfg.standby, 1'b0, cfg.tmo_off, cfg.fail_full_off,
                    cfg.xtal_sel, cfg.wd_period, cfg.wd_status};
      next_cfg.wd_status = 1'b0;
    end
    if (req.wr && cfg_hit) begin
      if (req.wdata[`FGCW_BIT_SOFT_RESET]) begin
        // self-clearing: only a one-cycle pulse, never stored
        next_cfg        = '0;
        next_strap_cnt  = 2'h0;
        next_regs_reset = 1'b1;
      end else begin
        next_cfg.standby       = req.wdata[`FGCW_BIT_STANDBY];
        next_cfg.tmo_off       = req.wdata[`FGCW_BIT_TMO_OFF];
        next_cfg.fail_full_off = req.wdata[`FGCW_BIT_FAIL_FULL];
        next_cfg.xtal_sel      = req.wdata[`FGCW_BIT_XTAL_SEL];
        next_cfg.wd_period     = req.wdata[`FGCW_BIT_WD_HI:`FGCW_BIT_WD_LO];
      end
    end
    // set wins over the read clear
    if (wd_expire)
      next_cfg.wd_status = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg        <= '0;
      rdata      <= 8'h00;
      strap_cnt  <= 2'h0;
      regs_reset <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      rdata      <= next_rdata;
      strap_cnt  <= next_strap_cnt;
      regs_reset <= next_regs_reset;
    end
  end

  // ==========================================================
  // bus stuck-low timeout
  logic [31:0] sda_cnt, next_sda_cnt;
  logic        next_bus_reset;
  always_comb begin
    next_sda_cnt   = 32'h0000_0000;
    next_bus_reset = 1'b0;
    if (!sda_s && !cfg.tmo_off) begin
      next_sda_cnt = sda_cnt + 32'h0000_0001;
      if (sda_cnt >= BUS_TMO_CYC) begin
        next_bus_reset = 1'b1;
        next_sda_cnt   = 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // watchdog: one-second tick, seconds counter
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [31:0] sec_cnt, next_sec_cnt;
  logic        wd_fired, next_wd_fired;
  logic        next_hold, next_full;
  always_comb begin
    next_tick_cnt = tick_cnt + 32'h0000_0001;
    next_sec_cnt  = sec_cnt;
    next_wd_fired = wd_fired;
    wd_expire     = 1'b0;
    if (tick_cnt >= TICK_CYC - 1) begin
      next_tick_cnt = 32'h0000_0000;
      next_sec_cnt  = sec_cnt + 32'h0000_0001;
    end
    // a transaction in the expiry cycle restarts the period instead
    if (cfg.wd_period != 2'b00 && !wd_fired && !req.txn_ok &&
        sec_cnt >= wd_cycles(cfg.wd_period)) begin
      next_wd_fired = 1'b1;
      wd_expire     = 1'b1;
    end
    if (req.txn_ok || cfg.wd_period == 2'b00) begin
      next_tick_cnt = 32'h0000_0000;
      next_sec_cnt  = 32'h0000_0000;
      next_wd_fired = 1'b0;
    end
    // drives are frozen, not cleared, so they come back on resume
    next_hold = next_wd_fired;
    next_full = next_wd_fired ||
                (fan_fail_any && !cfg.fail_full_off);
  end

  // ==========================================================
  // oscillator selection with fallback
  fgcw_osc_e   osc, next_osc;
  logic        xclk_d;
  logic [15:0] edge_cnt, next_edge_cnt;
  logic [31:0] dead_cnt, next_dead_cnt;
  logic        xedge;
  assign xedge = xclk_s && !xclk_d;
  always_comb begin
    next_osc      = osc;
    next_edge_cnt = edge_cnt;
    next_dead_cnt = xedge ? 32'h0000_0000 : dead_cnt + 32'h0000_0001;
    case (osc)
      FGCW_OSC_INT: begin
        next_edge_cnt = 16'h0000;
        if (cfg.xtal_sel)
          next_osc = FGCW_OSC_WAIT;
      end
      FGCW_OSC_WAIT: begin
        if (xedge)
          next_edge_cnt = edge_cnt + 16'h0001;
        if (!cfg.xtal_sel)
          next_osc = FGCW_OSC_INT;
        else if (edge_cnt >= 16'(XTAL_EDGES))
          next_osc = FGCW_OSC_XTAL;
        // a crystal that never starts keeps us waiting on internal
      end
      FGCW_OSC_XTAL: begin
        if (!cfg.xtal_sel || dead_cnt >= XTAL_DEAD)
          next_osc = FGCW_OSC_INT;
      end
      default: next_osc = FGCW_OSC_INT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn || regs_reset) begin
      bus_reset     <= 1'b0;
      sda_cnt       <= 32'h0000_0000;
      tick_cnt      <= 32'h0000_0000;
      sec_cnt       <= 32'h0000_0000;
      wd_fired      <= 1'b0;
      hold_drive    <= 1'b0;
      all_fans_full <= 1'b0;
      osc           <= FGCW_OSC_INT;
      xclk_d        <= 1'b0;
      edge_cnt      <= 16'h0000;
      dead_cnt      <= 32'h0000_0000;
      use_xtal      <= 1'b0;
      standby       <= 1'b0;
    end else begin
      bus_reset     <= next_bus_reset;
      sda_cnt       <= next_sda_cnt;
      tick_cnt      <= next_tick_cnt;
      sec_cnt       <= next_sec_cnt;
      wd_fired      <= next_wd_fired;
      hold_drive    <= next_hold;
      all_fans_full <= next_full;
      osc           <= next_osc;
      xclk_d        <= xclk_s;
      edge_cnt      <= next_edge_cnt;
      dead_cnt      <= next_dead_cnt;
      use_xtal      <= next_osc == FGCW_OSC_XTAL;
      standby       <= next_cfg.standby;
    end
  end
endmodule // fgcw_top

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import fgcw_pkg::*;
  logic       clk = 0, rstn = 0, xtal_clk = 0, xrun = 0, fail = 0, wdp = 1;
  fgcw_req_s  req;
  fgcw_cfg_s  cfg;
  logic [7:0] rdata, d;
  logic       sda_in, standby, bus_reset, regs_reset, full, hold, use_xtal;
  int         error_cnt = 0, n_compared = 0, i, n;
  int         s[4] = '{0, 2, 6, 10};
  always #4 clk = ~clk;
  always #62.5 if (xrun) xtal_clk = ~xtal_clk;
  fgcw_top #(.BUS_TMO_CYC(200), .TICK_CYC(10), .XTAL_EDGES(4),
    .XTAL_DEAD(100)) u_dut (.clk, .rstn, .req, .sda_in, .xtal_clk,
    .watchdog_start_pin(wdp), .fan_fail_any(fail), .rdata, .cfg,
    .standby, .bus_reset, .regs_reset, .all_fans_full(full),
    .hold_drive(hold), .use_xtal);
  fgcw_host u_host (.clk, .rdata, .req, .sda_in);
  task results();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task rdc(input logic [7:0] e);
    u_host.xfer(1'b0, 8'h00, d);
    chk(d === e, "read value");
  endtask
  // ==========================================
  // scenarios
  task t_regs();
    rdc(8'h06);
    chk(cfg.wd_period === 2'b11, "strap period");
    chk(use_xtal === 1'b0, "not internal osc");
    u_host.xfer(1'b1, 8'hBA, d);
    rdc(8'hBA);
    chk(standby === 1'b1, "no standby");
    u_host.xfer(1'b1, 8'h7A, d);
    n = 0;
    for (i = 0; i < 3; i++) begin n += regs_reset; cyc(1); end
    chk(n == 1, "regs reset pulse");
    cyc(5);
    rdc(8'h06);
    wdp = 0;
    u_host.xfer(1'b1, 8'h40, d);
    cyc(5);
    rdc(8'h00);
  endtask
  task t_wd();
    for (int p = 1; p < 4; p++) begin
      u_host.xfer(1'b1, 8'(p << 1), d);
      for (i = 0; i < 120 && hold !== 1'b1; i++) cyc(1);
      chk(i >= 10 * s[p] - 3 && i <= 10 * s[p] + 3, "wd period");
      if (i == 120) results();
      chk(full === 1'b1, "wd not full");
      rdc(8'(p << 1) | 8'h01);
      chk(hold === 1'b0, "no restore");
      rdc(8'(p << 1));
    end
    u_host.xfer(1'b1, 8'h00, d);
    cyc(150);
    chk(hold === 1'b0, "wd inactive fired");
  endtask
  task t_fail();
    fail = 1;
    cyc(3);
    chk(full === 1'b1, "fail not full");
    u_host.xfer(1'b1, 8'h10, d);
    cyc(3);
    chk(full === 1'b0, "fail full disabled");
    fail = 0;
  endtask
  task t_tmo(input logic [7:0] c, input logic e);
    u_host.xfer(1'b1, c, d);
    u_host.sda_lo = 1;
    n = 0;
    for (i = 0; i < 260; i++) begin cyc(1); n += bus_reset; end
    u_host.sda_lo = 0;
    chk((n > 0) === e, "bus timeout");
  endtask
  task t_xtal();
    u_host.xfer(1'b1, 8'h08, d);
    cyc(60);
    chk(use_xtal === 1'b0, "xtal without clock");
    xrun = 1;
    for (i = 0; i < 200 && use_xtal !== 1'b1; i++) cyc(1);
    chk(i >= 50 && i < 200, "xtal startup");
    if (i == 200) results();
    xrun = 0;
    cyc(150);
    chk(use_xtal === 1'b0, "dead xtal kept");
  endtask
  initial begin
    cyc(20);
    rstn = 1;
    cyc(6);
    t_regs();
    t_wd();
    t_fail();
    t_tmo(8'h00, 1'b1);
    t_tmo(8'h20, 1'b0);
    t_xtal();
    results();
  end
endmodule // tb
